/* File: rtl/smc_consts.vh */
// Register map, field positions, reset values and timing counts of the sleep mode controller
`ifndef SMC_CONSTS_VH
`define SMC_CONSTS_VH
`define SMC_IDX_SLEEP_CONTROL 8'h00
`define SMC_IDX_REGULATOR_CONTROL 8'h01
`define SMC_IDX_CHANGE_PROTECTION 8'h02
`define SMC_IDX_STATUS 8'h03
`define SMC_IDX_WAKE_ENABLE 8'h04
`define SMC_IDX_CLOCK_CONFIG 8'h05
`define SMC_ADDR_SLEEP_CONTROL 12'h000
`define SMC_ADDR_REGULATOR_CONTROL 12'h004
`define SMC_ADDR_CHANGE_PROTECTION 12'h008
`define SMC_ADDR_STATUS 12'h00C
`define SMC_ADDR_WAKE_ENABLE 12'h010
`define SMC_ADDR_CLOCK_CONFIG 12'h014
`define SMC_SLEEP_ARM_BIT 0
`define SMC_SLEEP_SELECT_MSB 3
`define SMC_SLEEP_SELECT_LSB 1
`define SMC_HOT_LEAKAGE_CUT_BIT 4
`define SMC_DRIVE_SELECT_MSB 2
`define SMC_DRIVE_SELECT_LSB 0
`define SMC_SLEEP_CONTROL_RESET 8'h00
`define SMC_REGULATOR_CONTROL_RESET 8'h00
`define SMC_MODE_IDLE 3'h0
`define SMC_MODE_STANDBY 3'h1
`define SMC_MODE_POWER_DOWN 3'h2
`define SMC_DRIVE_AUTO 3'h0
`define SMC_DRIVE_FULL 3'h1
`define SMC_IO_UNLOCK_KEY 8'hD8
`define SMC_UNLOCK_WINDOW 3'h4
`define SMC_BOD_WAIT_READY 2'h3
`define SMC_WAKE_CYCLES 4'h6
`endif

/* File: rtl/smc_sleep_controller.v */
// Sleep mode controller: APB registers, sleep entry, clock gating, wake qualification and wake-up timing
// Function
// - Standby keeps peripheral only with run_in_standby
// - Counter needs run_in_standby; power-down keeps timer only
// - Main clock: idle on, standby on request
// - Watchdog oscillator always on; detector when sampled
// - Power-down: periodic timer; low-frequency oscillator only when in use
// - Pin interrupts wake all modes, async sensing
// - Address match wakes except hot power-down
// - Logic wakes power-down only asynchronous, cool
// - Receiver start-of-frame wakes only from standby
// - Wake after six cycles plus start-ups
// - Fuse code three extends wake until detector ready
// - Debug break forces return to active
// - Regulator control writable only after unlock
// - Sleep select field bits 3:1, three modes
// - Hot leakage bit 4, drive bits 2:0
// - Drive auto drops with low-frequency oscillator
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "smc_consts.vh"
module smc_sleep_controller #(
    parameter OSC_STARTUP_CYCLES = 16'd64,
    parameter REG_STARTUP_CYCLES = 16'd32
) (
    clock,
    nrst,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    sleepInstr,
    cpuInstrRetired,
    debugBreak,
    portPinIrq,
    vlmIrq,
    multiVoltageIoIrq,
    rtcCounterIrq,
    periodicTimerIrq,
    twoWireMatchIrq,
    configurableLogicIrq,
    lookupAsync,
    serialStartFrameIrq,
    timerIrq,
    otherIrq,
    runInStandbyReq,
    rtcRunInStandby,
    mainClockRunReq,
    lowFreqOscInUse,
    bodSampledMode,
    brownOutFuseActive,
    bodReady,
    cpuRun,
    asleep,
    sleepModeOut,
    mainClockEn,
    peripheralClockEn,
    rtcCounterEn,
    periodicTimerEn,
    watchdogOscEn,
    bodOscEn,
    lowFreqOscEn,
    configurableLogicClockEn,
    timerClockEn,
    regulatorFullDrive,
    hotLeakageCut
);
    localparam NPER = 8;
    input wire clock;
    input wire nrst;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output reg pready;
    output reg pslverr;
    input wire sleepInstr;
    input wire cpuInstrRetired;
    input wire debugBreak;
    input wire portPinIrq;
    input wire vlmIrq;
    input wire multiVoltageIoIrq;
    input wire rtcCounterIrq;
    input wire periodicTimerIrq;
    input wire twoWireMatchIrq;
    input wire configurableLogicIrq;
    input wire lookupAsync;
    input wire serialStartFrameIrq;
    input wire timerIrq;
    input wire otherIrq;
    input wire [NPER-1:0] runInStandbyReq;
    input wire rtcRunInStandby;
    input wire mainClockRunReq;
    input wire lowFreqOscInUse;
    input wire bodSampledMode;
    input wire [1:0] brownOutFuseActive;
    input wire bodReady;
    output reg cpuRun;
    output reg asleep;
    output reg [2:0] sleepModeOut;
    output reg mainClockEn;
    output reg [NPER-1:0] peripheralClockEn;
    output reg rtcCounterEn;
    output reg periodicTimerEn;
    output reg watchdogOscEn;
    output reg bodOscEn;
    output reg lowFreqOscEn;
    output reg configurableLogicClockEn;
    output reg timerClockEn;
    output reg regulatorFullDrive;
    output reg hotLeakageCut;

    localparam ST_ACTIVE = 2'h0;
    localparam ST_SLEEP = 2'h1;
    localparam ST_WAKE = 2'h2;

    // Wake sources and ready arrive from other logic; synchronised as a group
    wire [12:0] irqSync;
    smc_sync #(
        .WIDTH(13)
    ) u_sync (
        .clock(clock),
        .nrst(nrst),
        .asyncIn({bodReady, debugBreak, portPinIrq, vlmIrq, multiVoltageIoIrq, rtcCounterIrq, periodicTimerIrq,
            twoWireMatchIrq, configurableLogicIrq, lookupAsync, serialStartFrameIrq, timerIrq, otherIrq}),
        .syncOut(irqSync)
    );
    wire bodReadyS = irqSync[12];
    wire breakS = irqSync[11];
    wire pinS = irqSync[10];
    wire vlmS = irqSync[9];
    wire mvioS = irqSync[8];
    wire rtcCntS = irqSync[7];
    wire pitS = irqSync[6];
    wire twiS = irqSync[5];
    wire cclS = irqSync[4];
    wire lutAsyncS = irqSync[3];
    wire sofS = irqSync[2];
    wire tmrS = irqSync[1];
    wire othS = irqSync[0];

    reg [7:0] sleepControl_reg;
    reg [7:0] regulatorControl_reg;
    reg [9:0] wakeEnable_reg;
    reg [2:0] unlockCount_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [2:0] mode_reg;
    reg bodWait_reg;

    wire [2:0] sleepSelect = sleepControl_reg[`SMC_SLEEP_SELECT_MSB:`SMC_SLEEP_SELECT_LSB];
    wire sleepArm = sleepControl_reg[`SMC_SLEEP_ARM_BIT];
    wire hotCut = regulatorControl_reg[`SMC_HOT_LEAKAGE_CUT_BIT];
    wire [2:0] driveSelect = regulatorControl_reg[`SMC_DRIVE_SELECT_MSB:`SMC_DRIVE_SELECT_LSB];
    wire modeIdle = mode_reg == `SMC_MODE_IDLE;
    wire modeStby = mode_reg == `SMC_MODE_STANDBY;
    wire modePdn = mode_reg == `SMC_MODE_POWER_DOWN;

    // APB access completes in its access phase with zero wait states
    wire apbAccess = psel && penable;
    wire apbWrite = apbAccess && pwrite;
    wire unlocked = unlockCount_reg != 3'h0;

    always @(posedge clock) begin
        if (!nrst) begin
            unlockCount_reg <= 3'h0;
        end else if (apbWrite && paddr == `SMC_ADDR_CHANGE_PROTECTION && pwdata[7:0] == `SMC_IO_UNLOCK_KEY) begin
            unlockCount_reg <= `SMC_UNLOCK_WINDOW;
        end else if (apbWrite && paddr == `SMC_ADDR_REGULATOR_CONTROL) begin
            unlockCount_reg <= 3'h0;
        end else if (unlocked && cpuInstrRetired) begin
            unlockCount_reg <= unlockCount_reg - 3'h1;
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            sleepControl_reg <= `SMC_SLEEP_CONTROL_RESET;
            regulatorControl_reg <= `SMC_REGULATOR_CONTROL_RESET;
            wakeEnable_reg <= 10'h000;
        end else if (apbWrite) begin
            if (paddr == `SMC_ADDR_SLEEP_CONTROL) begin
                sleepControl_reg <= {4'h0, pwdata[3:0]};
            end else if (paddr == `SMC_ADDR_REGULATOR_CONTROL) begin
                if (unlocked) begin
                    // Bit 4 and bits 2:0 only
                    regulatorControl_reg <= {3'h0, pwdata[4], 1'b0, pwdata[2:0]};
                end
            end else if (paddr == `SMC_ADDR_WAKE_ENABLE) begin
                wakeEnable_reg <= pwdata[9:0];
            end
        end
    end

    always @(posedge clock) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable) begin
                if (paddr == `SMC_ADDR_SLEEP_CONTROL) begin
                    prdata <= {24'h000000, sleepControl_reg};
                end else if (paddr == `SMC_ADDR_REGULATOR_CONTROL) begin
                    prdata <= {24'h000000, regulatorControl_reg};
                end else if (paddr == `SMC_ADDR_CHANGE_PROTECTION) begin
                    prdata <= {31'h00000000, unlocked};
                end else if (paddr == `SMC_ADDR_STATUS) begin
                    prdata <= {27'h0000000, mode_reg, state_reg};
                end else if (paddr == `SMC_ADDR_WAKE_ENABLE) begin
                    prdata <= {22'h000000, wakeEnable_reg};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // Wake qualification per mode; enable bits follow the synchroniser order
    reg wakeQual;
    always @* begin
        wakeQual = 1'b0;
        wakeQual = wakeQual | (pinS && wakeEnable_reg[9]);
        wakeQual = wakeQual | (vlmS && wakeEnable_reg[8]) | (mvioS && wakeEnable_reg[7]);
        wakeQual = wakeQual | (pitS && wakeEnable_reg[5]);
        wakeQual = wakeQual | (rtcCntS && wakeEnable_reg[6] && (modeIdle || (modeStby && rtcRunInStandby)));
        // Address match gated by hot cut
        wakeQual = wakeQual | (twiS && wakeEnable_reg[4] && !(modePdn && hotCut));
        wakeQual = wakeQual | (cclS && wakeEnable_reg[3] && (modeIdle || modeStby || (modePdn && !hotCut && lutAsyncS)));
        // Start of frame in standby only
        wakeQual = wakeQual | (sofS && wakeEnable_reg[2] && modeStby);
        wakeQual = wakeQual | (tmrS && wakeEnable_reg[1] && (modeIdle || (modeStby && runInStandbyReq[0])));
        wakeQual = wakeQual | (othS && wakeEnable_reg[0] && modeIdle);
    end

    wire anyStandbyRun = (|runInStandbyReq) || mainClockRunReq;
    wire [15:0] startupLoad = ((modeStby && !anyStandbyRun) || modePdn) ?
        (OSC_STARTUP_CYCLES + REG_STARTUP_CYCLES + {12'h000, `SMC_WAKE_CYCLES}) : {12'h000, `SMC_WAKE_CYCLES};
    reg timerLoad;
    wire timerDone;
    smc_wake_timer #(
        .WIDTH(16)
    ) u_wake_timer (
        .clock(clock),
        .nrst(nrst),
        .load(timerLoad),
        .loadValue(startupLoad),
        .expired(timerDone)
    );

    always @* begin
        state_next = state_reg;
        timerLoad = 1'b0;
        case (state_reg)
            ST_ACTIVE: begin
                // Armed sleep with a valid mode only
                if (sleepInstr && sleepArm && sleepSelect <= `SMC_MODE_POWER_DOWN) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wakeQual || breakS) begin
                    state_next = ST_WAKE;
                    timerLoad = 1'b1;
                end
            end
            ST_WAKE: begin
                if (timerDone && (!bodWait_reg || bodReadyS)) begin
                    state_next = ST_ACTIVE;
                end
            end
            default: begin
                state_next = ST_ACTIVE;
            end
        endcase
    end

    always @(posedge clock) begin
        if (!nrst) begin
            state_reg <= ST_ACTIVE;
            mode_reg <= `SMC_MODE_IDLE;
            bodWait_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_ACTIVE && state_next == ST_SLEEP) begin
                mode_reg <= sleepSelect;
            end
            bodWait_reg <= brownOutFuseActive == `SMC_BOD_WAIT_READY;
        end
    end

    // Gating outputs registered; in wake state clocks restart as in active
    wire sleeping = state_next == ST_SLEEP;
    wire [2:0] nextMode = (state_reg == ST_ACTIVE) ? sleepSelect : mode_reg;
    wire nIdle = nextMode == `SMC_MODE_IDLE;
    wire nStby = nextMode == `SMC_MODE_STANDBY;
    wire nPdn = nextMode == `SMC_MODE_POWER_DOWN;
    always @(posedge clock) begin
        if (!nrst) begin
            cpuRun <= 1'b1;
            asleep <= 1'b0;
            sleepModeOut <= `SMC_MODE_IDLE;
            mainClockEn <= 1'b1;
            peripheralClockEn <= {NPER{1'b1}};
            rtcCounterEn <= 1'b1;
            periodicTimerEn <= 1'b1;
            watchdogOscEn <= 1'b1;
            bodOscEn <= 1'b1;
            lowFreqOscEn <= 1'b1;
            configurableLogicClockEn <= 1'b1;
            timerClockEn <= 1'b1;
            regulatorFullDrive <= 1'b1;
            hotLeakageCut <= 1'b0;
        end else begin
            cpuRun <= state_next == ST_ACTIVE;
            asleep <= sleeping;
            sleepModeOut <= nextMode;
            mainClockEn <= !sleeping || nIdle || (nStby && anyStandbyRun);
            peripheralClockEn <= (!sleeping || nIdle) ? {NPER{1'b1}} : (nStby ? runInStandbyReq : {NPER{1'b0}});
            rtcCounterEn <= !sleeping || nIdle || (nStby && rtcRunInStandby);
            periodicTimerEn <= 1'b1;
            watchdogOscEn <= 1'b1;
            bodOscEn <= !sleeping || bodSampledMode;
            lowFreqOscEn <= !(sleeping && nPdn) || lowFreqOscInUse;
            configurableLogicClockEn <= !sleeping || nIdle || (nStby && runInStandbyReq[1]);
            timerClockEn <= !sleeping || nIdle;
            // Auto drive drops with low-frequency only
            regulatorFullDrive <= (driveSelect == `SMC_DRIVE_FULL) ||
                !(sleeping && lowFreqOscInUse && !anyStandbyRun && !nIdle);
            hotLeakageCut <= sleeping && nPdn && hotCut && driveSelect == `SMC_DRIVE_AUTO;
        end
    end
endmodule // smc_sleep_controller

/* File: rtl/smc_sync.v */
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
module smc_sync #(
    parameter WIDTH = 1
) (
    clock,
    nrst,
    asyncIn,
    syncOut
);
    input wire clock;
    input wire nrst;
    input wire [WIDTH-1:0] asyncIn;
    output reg [WIDTH-1:0] syncOut;
    reg [WIDTH-1:0] stage_reg;
    always @(posedge clock) begin
        if (!nrst) begin
            stage_reg <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            stage_reg <= asyncIn;
            syncOut <= stage_reg;
        end
    end
endmodule // smc_sync

/* File: rtl/smc_wake_timer.v */
// Down counter for the wake-up delay
`timescale 1ns/100ps
module smc_wake_timer #(
    parameter WIDTH = 16
) (
    clock,
    nrst,
    load,
    loadValue,
    expired
);
    input wire clock;
    input wire nrst;
    input wire load;
    input wire [WIDTH-1:0] loadValue;
    output wire expired;
    reg [WIDTH-1:0] count_reg;
    always @(posedge clock) begin
        if (!nrst) begin
            count_reg <= {WIDTH{1'b0}};
        end else if (load) begin
            count_reg <= loadValue;
        end else if (count_reg != {WIDTH{1'b0}}) begin
            count_reg <= count_reg - 1'b1;
        end
    end
    assign expired = (count_reg == {WIDTH{1'b0}}) && !load;
endmodule // smc_wake_timer

/* File: sim/smc_cpu_model.sv */
// Core model: issues the sleep instruction and retires instructions
`timescale 1ns/100ps
module smc_cpu_model (
    input logic clock,
    input logic nrst,
    input logic cpuRun,
    input logic sleepReq,
    output logic sleepInstr,
    output logic cpuInstrRetired
);
    always @(posedge clock) begin
        if (!nrst) begin
            sleepInstr <= 1'b0;
            cpuInstrRetired <= 1'b0;
        end else begin
            // Instruction count, one every other cycle
            cpuInstrRetired <= cpuRun && !cpuInstrRetired;
            // Sleep only issued by a running core
            sleepInstr <= sleepReq && cpuRun;
        end
    end
endmodule // smc_cpu_model

/* File: sim/smc_sleep_controller_chk.sv */
// Port-level property checker for the sleep mode controller
`timescale 1ns/100ps
module smc_sleep_controller_chk #(
    parameter OSC_STARTUP_CYCLES = 16'd64,
    parameter REG_STARTUP_CYCLES = 16'd32
) (
    input logic clock,
    input logic nrst,
    input logic sleepInstr,
    input logic debugBreak,
    input logic [7:0] runInStandbyReq,
    input logic mainClockRunReq,
    input logic bodSampledMode,
    input logic [1:0] brownOutFuseActive,
    input logic bodReady,
    input logic cpuRun,
    input logic asleep,
    input logic [2:0] sleepModeOut,
    input logic mainClockEn,
    input logic [7:0] peripheralClockEn,
    input logic watchdogOscEn,
    input logic bodOscEn,
    input logic configurableLogicClockEn,
    input logic timerClockEn
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [15:0] sleepCnt;
    // Saturates so a very long sleep cannot wrap to a small count
    always @(posedge clock) begin
        if (!nrst || cpuRun)
            sleepCnt <= 16'h0000;
        else if (sleepCnt != 16'hFFFF)
            sleepCnt <= sleepCnt + 16'h0001;
    end
    entry_needs_instr_a: assert property ($rose(asleep) |-> $past(sleepInstr) || $past(sleepInstr, 2))
        else $error("sleep entered without a sleep instruction");
    idle_main_on_a: assert property (asleep && sleepModeOut == 3'h0 |-> mainClockEn)
        else $error("main clock stopped in idle");
    standby_gated_a: assert property ($rose(asleep) && sleepModeOut == 3'h1 && runInStandbyReq == 8'h00
        && !mainClockRunReq |=> !mainClockEn && peripheralClockEn == 8'h00)
        else $error("standby left clocks running without request");
    power_down_code_clocks_off_a: assert property ($rose(asleep) && sleepModeOut == 3'h2
        |=> !mainClockEn && !configurableLogicClockEn && !timerClockEn)
        else $error("power-down left a fast clock running");
    watchdog_osc_a: assert property (asleep |-> watchdogOscEn)
        else $error("watchdog oscillator stopped in sleep");
    bod_sampled_osc_a: assert property (asleep && bodSampledMode |-> bodOscEn)
        else $error("detector oscillator stopped in sampled mode");
    wake_six_min_a: assert property ($rose(cpuRun) |-> sleepCnt >= 16'd6)
        else $error("resumed in fewer than six cycles");
    debug_wake_a: assert property (asleep && debugBreak && brownOutFuseActive != 2'h3 |-> ##[1:300] cpuRun)
        else $error("debug break did not wake the core");
    bod_hold_a: assert property ((!cpuRun && brownOutFuseActive == 2'h3 && !bodReady)[*4] |=> !cpuRun)
        else $error("woke before detector ready");
    cover property ($rose(asleep) && sleepModeOut == 3'h0);
    cover property ($rose(asleep) && sleepModeOut == 3'h1);
    cover property ($rose(asleep) && sleepModeOut == 3'h2);
    cover property ($rose(cpuRun) && sleepCnt >= OSC_STARTUP_CYCLES + REG_STARTUP_CYCLES + 16'd6);
endmodule // smc_sleep_controller_chk
bind smc_sleep_controller smc_sleep_controller_chk #(
    .OSC_STARTUP_CYCLES(OSC_STARTUP_CYCLES),
    .REG_STARTUP_CYCLES(REG_STARTUP_CYCLES)
) u_chk (.*);

/* File: sim/tb_top.sv */
// Self-checking bench for the sleep mode controller
`timescale 1ns/100ps
module tb_top;
    localparam logic [15:0] OSC = 16'd16;
    localparam logic [15:0] REG = 16'd8;
    logic clock, nrst, psel, penable, pwrite, pready, pslverr, sleepReq, sleepInstr, cpuInstrRetired, debugBreak;
    logic lookupAsync, bodReady, mainClockRunReq, lowFreqOscInUse, bodSampledMode, rtcRunInStandby;
    logic cpuRun, asleep, mainClockEn, rtcCounterEn, periodicTimerEn, watchdogOscEn, bodOscEn, lowFreqOscEn;
    logic configurableLogicClockEn, timerClockEn, regulatorFullDrive, hotLeakageCut, gotErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [9:0] irqVec;
    logic [7:0] runInStandbyReq, peripheralClockEn;
    logic [2:0] sleepModeOut, md;
    logic [1:0] brownOutFuseActive;
    int num_errors = 0;
    int checks = 0;
    int n;
    wire portPinIrq = irqVec[9], vlmIrq = irqVec[8], multiVoltageIoIrq = irqVec[7], rtcCounterIrq = irqVec[6],
        periodicTimerIrq = irqVec[5], twoWireMatchIrq = irqVec[4], configurableLogicIrq = irqVec[3],
        serialStartFrameIrq = irqVec[2], timerIrq = irqVec[1], otherIrq = irqVec[0];
    // Rows: {mode[2:0], hot, source index[3:0], expect wake}
    logic [8:0] rows [12] = '{9'h001, 9'h003, 9'h004, 9'h045, 9'h053, 9'h093, 9'h089, 9'h0A8, 9'h087,
        9'h0A6, 9'h080, 9'h084};
    smc_sleep_controller #(.OSC_STARTUP_CYCLES(OSC), .REG_STARTUP_CYCLES(REG)) dut (.*);
    smc_cpu_model partner (.*);
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task final_report;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clock);
            k++;
        end
        // Read data and error are taken only at the edge that sees pready
        q = prdata;
        gotErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            num_errors++;
            final_report();
        end
    endtask
    task regWrite(input logic [31:0] d);
        apb(1'b1, 12'h008, 32'h000000D8);
        apb(1'b1, 12'h004, d);
    endtask
    task sleepGo(input logic [31:0] ctrl);
        apb(1'b1, 12'h000, ctrl);
        @(posedge clock);
        sleepReq <= 1'b1;
        @(posedge clock);
        sleepReq <= 1'b0;
        repeat (3) @(negedge clock);
    endtask
    task wake(input logic [9:0] v, input int bound);
        @(posedge clock);
        irqVec <= v;
        debugBreak <= (v == 10'h000);
        n = 0;
        @(negedge clock);
        while (cpuRun !== 1'b1 && n < bound) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        irqVec <= 10'h000;
        debugBreak <= 1'b0;
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        num_errors++;
        final_report();
    end
    initial begin
        {nrst, psel, penable, pwrite, sleepReq, debugBreak, bodReady, mainClockRunReq, lowFreqOscInUse} = '0;
        {rtcRunInStandby, paddr, pwdata, irqVec, runInStandbyReq, brownOutFuseActive} = '0;
        lookupAsync = 1'b1;
        bodSampledMode = 1'b1;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        chk(32'({cpuRun, asleep, mainClockEn, watchdogOscEn, regulatorFullDrive, hotLeakageCut}), 32'h2E);
        apb(1'b0, 12'h000, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(gotErr), 32'h1);
        apb(1'b1, 12'h004, 32'h11);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0);
        apb(1'b1, 12'h008, 32'hD8);
        repeat (12) @(posedge clock);
        apb(1'b1, 12'h004, 32'h11);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0);
        regWrite(32'h11);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h11);
        apb(1'b1, 12'h010, 32'h3FF);
        sleepGo(32'h04);
        chk(32'(asleep), 32'h0);
        sleepGo(32'h07);
        chk(32'(asleep), 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(q, 32'h07);
        foreach (rows[i]) begin
            md = rows[i][8:6];
            // Leakage cut is only ever set for power-down rows
            regWrite(32'({rows[i][5], 4'h0}));
            sleepGo(32'({md, 1'b1}));
            chk(32'({asleep, sleepModeOut}), 32'({1'b1, md}));
            chk(32'({hotLeakageCut, lowFreqOscEn}), 32'({md == 3'h2 && rows[i][5], md != 3'h2}));
            chk(32'({rtcCounterEn, periodicTimerEn, regulatorFullDrive}), 32'({md == 3'h0, 2'b11}));
            wake(10'h001 << rows[i][4:1], 300);
            chk(32'(n < 300), 32'(rows[i][0]));
            // Sleep again so the break always finds the core asleep
            sleepGo(32'({md, 1'b1}));
            chk(32'(asleep), 32'h1);
            wake(10'h000, 300);
            chk(32'(n < 300), 32'h1);
        end
        regWrite(32'h0);
        sleepGo(32'h01);
        wake(10'h001, 300);
        chk(32'(n >= 6 && n <= 12), 32'h1);
        lowFreqOscInUse <= 1'b1;
        sleepGo(32'h05);
        chk(32'({regulatorFullDrive, lowFreqOscEn, mainClockEn}), 32'h2);
        wake(10'h200, 300);
        chk(32'(n >= 6 + OSC + REG && n <= 16 + OSC + REG), 32'h1);
        lowFreqOscInUse <= 1'b0;
        runInStandbyReq <= 8'h01;
        sleepGo(32'h03);
        chk(32'({peripheralClockEn, mainClockEn}), 32'h03);
        wake(10'h000, 300);
        brownOutFuseActive <= 2'h3;
        sleepGo(32'h01);
        wake(10'h001, 40);
        chk(32'(cpuRun), 32'h0);
        bodReady <= 1'b1;
        wake(10'h001, 20);
        chk(32'(cpuRun), 32'h1);
        final_report();
    end
endmodule // tb_top
